// ===== fsr_consts.svh
// Purpose: Opcodes, bit positions, reset values and timing counts of the flash status/config block
// Assumes: System clock of 50 MHz
// Notes:   Definitions only
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

// ****************************************
// Serial commands
// ****************************************
`define FSR_OP_WRITE_ENABLE   8'h06
`define FSR_OP_WRITE_DISABLE  8'h04
`define FSR_OP_READ_STATUS_LO 8'h05
`define FSR_OP_READ_STATUS_HI 8'h35
`define FSR_OP_READ_CONFIG    8'h15
`define FSR_OP_WRITE_STATUS   8'h01
`define FSR_OP_WRITE_STATUS2  8'h31
`define FSR_OP_SUSPEND        8'h75
`define FSR_OP_RESUME         8'h7a

// ****************************************
// Frame lengths in link bits
// ****************************************
`define FSR_OPCODE_BITS 5'h08
`define FSR_ONE_BYTE    5'h10
`define FSR_TWO_BYTES   5'h18
`define FSR_BIT_LIMIT   5'h1c

// ****************************************
// Reset values and field masks
// ****************************************
`define FSR_STATUS_RESET 16'h0000
`define FSR_CONFIG_RESET 8'h00
`define FSR_CONFIG_MASK  8'h8f
`define FSR_LEARN_BYTE   8'h34

// ****************************************
// Dummy counts
// ****************************************
`define FSR_DUAL_DUMMY_SHORT 4'h4
`define FSR_DUAL_DUMMY_LONG  4'h8
`define FSR_QUAD_DUMMY_SHORT 4'h6
`define FSR_QUAD_DUMMY_LONG  4'ha

// ****************************************
// Status write time
// ****************************************
`define FSR_CLK_PERIOD_NS    20
`define FSR_STATUS_WRITE_NS  5000000
`define FSR_STATUS_WRITE_CYC ((`FSR_STATUS_WRITE_NS) / (`FSR_CLK_PERIOD_NS))

`endif

// ===== fsr_host.sv
// Purpose: Behavioural host controller on the single-line serial link
// Assumes: Link clock period 160 ns, unrelated in phase to sys_clk
// Notes:   Data line idles at the inverse of its last bit between frames
`timescale 1ns/100ps
`default_nettype none
module fsr_host (
	// Link to device
	output var fsr_pkg::fsr_pins_s pins,
	input  wire logic [3:0]        io_out,
	input  wire logic              wp_lvl
);
	import fsr_pkg::*;
	localparam int HALF = 80;
	initial begin
		pins.cs_n = 1'b1;
		pins.sclk = 1'b0;
		pins.io = 4'h0;
		pins.wp_n = 1'b1;
	end
	always @(wp_lvl) pins.wp_n = wp_lvl;
	// ****************************************
	// One framed command: opcode, data bits, read bits
	// ****************************************
	task automatic frame(input logic [7:0] op, input logic [15:0] d, input int nd, input int nr,
		output logic [7:0] rd);
		logic [23:0] sh;
		sh = {op, d};
		rd = 8'h00;
		#3 pins.cs_n = 1'b0;
		#(HALF);
		// Opcode then data, most significant bit first
		for (int i = 0; i < 8 + nd; i++) begin
			pins.io[0] = sh[23 - i];
			#(HALF) pins.sclk = 1'b1;
			#(HALF) pins.sclk = 1'b0;
		end
		// Read bit taken late in the high phase, once the answer has settled
		for (int i = 0; i < nr; i++) begin
			#(HALF) pins.sclk = 1'b1;
			#70 rd = {rd[6:0], io_out[1]};
			#10 pins.sclk = 1'b0;
		end
		#(HALF) pins.cs_n = 1'b1;
		pins.io[0] = ~pins.io[0];
		#(4 * HALF);
	endtask : frame
endmodule : fsr_host
`default_nettype wire

// ===== fsr_pkg.sv
// Purpose: Types of the flash status/config block
// Assumes: Nothing
// Notes:   Constants live in fsr_consts.svh
package fsr_pkg;

	// Pins sampled from the serial link
	typedef struct packed {
		logic       wp_n;
		logic       cs_n;
		logic       sclk;
		logic [3:0] io;
	} fsr_pins_s;

	// Status word, most significant bit first
	typedef struct packed {
		logic       pause_flag;
		logic       protect_complement;
		logic       security_lock_three;
		logic       security_lock_two;
		logic       security_lock_one;
		logic       erase_fail;
		logic       quad_enable;
		logic       register_protect_high;
		logic       register_protect_low;
		logic [4:0] block_protect_bits;
		logic       write_enable_latch;
		logic       write_busy;
	} fsr_status_s;

	// Configuration byte
	typedef struct packed {
		logic       hold_reset_select;
		logic [2:0] reserved;
		logic       large_page_select;
		logic       protect_scheme_select;
		logic       dummy_count_select;
		logic       learning_pattern_enable;
	} fsr_config_s;

	// Link frame states
	typedef enum logic [2:0] {
		FSR_IDLE,
		FSR_OPCODE,
		FSR_WDATA,
		FSR_READ,
		FSR_SKIP
	} fsr_state_e;

endpackage : fsr_pkg

// ===== fsr_regs.sv
// Purpose: Status and configuration register logic of a serial NOR flash, with its serial command front end
// Assumes: Link pins are sampled by sys_clk; qpi_mode, array_busy and erase_fail come from sys_clk logic
// Notes:   Operation
`include "fsr_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module fsr_regs #(
	parameter int unsigned STATUS_WRITE_CYCLES = `FSR_STATUS_WRITE_CYC
) (
	// Clock and reset
	input  wire  logic              sys_clk,
	input  wire  logic              nrst,
	// Serial link
	input  wire  fsr_pkg::fsr_pins_s pins,
	output logic [3:0]              io_out,
	output logic [3:0]              io_oe,
	// Core side levels
	input  wire  logic              qpi_mode,
	input  wire  logic              array_busy,
	input  wire  logic              erase_fail,
	// Page buffer load address
	input  wire  logic              buf_load,
	input  wire  logic [8:0]        buf_start,
	input  wire  logic              buf_strobe,
	output logic [8:0]              buf_addr,
	// Configuration effects
	output logic                    erase_dual_page,
	output logic                    pin_hold_enable,
	output logic                    pin_reset_enable,
	output logic                    use_block_locks,
	output logic                    block_locks_preset,
	output logic [3:0]              dual_dummy,
	output logic [3:0]              quad_dummy,
	output logic [7:0]              learn_pattern,
	// Register views
	output fsr_pkg::fsr_status_s    status_word,
	output fsr_pkg::fsr_config_s    config_byte
);
	import fsr_pkg::*;

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_pipe;
	logic       rst_n;

	// Released two clocks after nrst rises
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	// ****************************************
	// Pin sampling
	// ****************************************
	fsr_pins_s pin_q;
	logic      sclk_d;
	logic      cs_d;
	logic      sclk_rise;
	logic      sclk_fall;
	logic      cs_rise;

	fsr_sync #(
		.WIDTH (7),
		.INIT  (7'h60)
	) u_pin_sync (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.d     (pins),
		.q     (pin_q)
	);

	// Previous levels for edge finding
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end else begin
			sclk_d <= pin_q.sclk;
			cs_d   <= pin_q.cs_n;
		end
	end
	assign sclk_rise = pin_q.sclk & ~sclk_d & ~pin_q.cs_n;
	assign sclk_fall = ~pin_q.sclk & sclk_d & ~pin_q.cs_n;
	assign cs_rise   = pin_q.cs_n & ~cs_d;

	// ****************************************
	// Link frame
	// ****************************************
	fsr_state_e  state, next_state;
	logic [4:0]  bit_cnt, next_bit_cnt;
	logic [23:0] shreg, next_shreg;
	logic [7:0]  opcode, next_opcode;
	logic [7:0]  out_sh, next_out_sh;
	logic [3:0]  out_cnt, next_out_cnt;
	logic [3:0]  next_io_out, next_io_oe;
	logic [4:0]  step;
	logic [23:0] shifted;
	logic [7:0]  read_value;
	fsr_status_s st;
	fsr_config_s cfg;

	assign step    = qpi_mode ? 5'h4 : 5'h1;
	assign shifted = qpi_mode ? {shreg[19:0], pin_q.io} : {shreg[22:0], pin_q.io[0]};

	// Byte answered by the read commands; status reads never wait on the write cycle
	always_comb begin
		case (opcode)
			`FSR_OP_READ_STATUS_HI: read_value = st[15:8];
			`FSR_OP_READ_CONFIG:    read_value = cfg;
			default:                read_value = {st[7:1], st.write_busy | array_busy};
		endcase
	end

	// Frame decoding and read shifting
	always_comb begin
		next_state   = state;
		next_bit_cnt = bit_cnt;
		next_shreg   = shreg;
		next_opcode  = opcode;
		next_out_sh  = out_sh;
		next_out_cnt = out_cnt;
		next_io_out  = io_out;
		next_io_oe   = io_oe;
		if (pin_q.cs_n) begin
			next_state   = FSR_IDLE;
			next_bit_cnt = 5'h0;
			next_io_oe   = 4'h0;
		end else begin
			case (state)
				FSR_IDLE: begin
					next_state = FSR_OPCODE;
				end
				FSR_OPCODE: begin
					if (sclk_rise) begin
						next_shreg   = shifted;
						next_bit_cnt = bit_cnt + step;
						if (next_bit_cnt == `FSR_OPCODE_BITS) begin
							next_opcode = shifted[7:0];
							case (shifted[7:0])
								`FSR_OP_READ_STATUS_LO,
								`FSR_OP_READ_STATUS_HI,
								`FSR_OP_READ_CONFIG:   next_state = FSR_READ;
								`FSR_OP_WRITE_STATUS,
								`FSR_OP_WRITE_STATUS2: next_state = FSR_WDATA;
								default:               next_state = FSR_SKIP;
							endcase
							next_out_cnt = 4'h0;
						end
					end
				end
				FSR_WDATA: begin
					if (sclk_rise) begin
						next_shreg = shifted;
						if (bit_cnt < `FSR_BIT_LIMIT) begin
							next_bit_cnt = bit_cnt + step;
						end
					end
				end
				FSR_READ: begin
					// Other lines are ignored as inputs in single mode
					if (sclk_fall) begin
						if (out_cnt == 4'h0) begin
							next_out_sh = read_value;
						end
						if (qpi_mode) begin
							next_io_out = (out_cnt == 4'h0) ? read_value[7:4] : out_sh[7:4];
							next_io_oe  = 4'hf;
						end else begin
							next_io_out = {2'h0, (out_cnt == 4'h0) ? read_value[7] : out_sh[7], 1'b0};
							next_io_oe  = 4'h2;
						end
						if (out_cnt != 4'h0) begin
							next_out_sh = qpi_mode ? {out_sh[3:0], 4'h0} : {out_sh[6:0], 1'b0};
						end else begin
							next_out_sh = qpi_mode ? {read_value[3:0], 4'h0} : {read_value[6:0], 1'b0};
						end
						next_out_cnt = (out_cnt + step[3:0] >= 4'h8) ? 4'h0 : out_cnt + step[3:0];
					end
				end
				default: begin
					next_state = FSR_SKIP;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= FSR_IDLE;
			bit_cnt <= 5'h0;
			shreg   <= 24'h0;
			opcode  <= 8'h0;
			out_sh  <= 8'h0;
			out_cnt <= 4'h0;
			io_out  <= 4'h0;
			io_oe   <= 4'h0;
		end else begin
			state   <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg   <= next_shreg;
			opcode  <= next_opcode;
			out_sh  <= next_out_sh;
			out_cnt <= next_out_cnt;
			io_out  <= next_io_out;
			io_oe   <= next_io_oe;
		end
	end

	// ****************************************
	// Status and configuration registers
	// ****************************************
	fsr_status_s next_st;
	fsr_config_s next_cfg;
	logic [31:0] tw_cnt, next_tw_cnt;
	logic        hw_locked;
	logic        is_write;
	logic        write_ok;
	logic [7:0]  byte1;
	logic [7:0]  byte2;
	logic [7:0]  hi_byte;

	// Locked by protect-high, or protect-low with the pin low; pin only counts without quad
	assign hw_locked = st.register_protect_high |
	                   (st.register_protect_low & ~pin_q.wp_n & ~st.quad_enable);
	assign is_write  = (opcode == `FSR_OP_WRITE_STATUS) || (opcode == `FSR_OP_WRITE_STATUS2);
	assign write_ok  = cs_rise && state == FSR_WDATA && is_write && st.write_enable_latch &&
	                   !hw_locked && !st.write_busy &&
	                   (bit_cnt == `FSR_ONE_BYTE || bit_cnt == `FSR_TWO_BYTES);
	assign byte1     = (bit_cnt == `FSR_TWO_BYTES) ? shreg[15:8] : shreg[7:0];
	assign byte2     = shreg[7:0];
	// Byte that lands in the upper status half
	assign hi_byte   = (opcode == `FSR_OP_WRITE_STATUS2) ? byte1 : byte2;

	// Command effects at the end of each frame, then the write timer
	always_comb begin
		next_st            = st;
		next_cfg           = cfg;
		next_tw_cnt        = tw_cnt;
		next_st.erase_fail = erase_fail;
		if (cs_rise && state == FSR_SKIP && !st.write_busy) begin
			if (opcode == `FSR_OP_WRITE_ENABLE) begin
				next_st.write_enable_latch = 1'b1;
			end
			if (opcode == `FSR_OP_WRITE_DISABLE) begin
				next_st.write_enable_latch = 1'b0;
			end
		end
		if (cs_rise && state == FSR_SKIP) begin
			if (opcode == `FSR_OP_SUSPEND) begin
				next_st.pause_flag = 1'b1;
			end
			if (opcode == `FSR_OP_RESUME) begin
				next_st.pause_flag = 1'b0;
			end
		end
		// Pause flag, fail bit, latch and busy are never loaded from data
		if (write_ok) begin
			if (opcode == `FSR_OP_WRITE_STATUS) begin
				next_st.register_protect_low = byte1[7];
				next_st.block_protect_bits   = byte1[6:2];
				if (bit_cnt == `FSR_ONE_BYTE) begin
					next_st.protect_complement    = 1'b0;
					next_st.quad_enable           = 1'b0;
					next_st.register_protect_high = 1'b0;
				end
			end
			if (opcode == `FSR_OP_WRITE_STATUS2 || bit_cnt == `FSR_TWO_BYTES) begin
				next_st.protect_complement    = hi_byte[6];
				next_st.security_lock_three   = st.security_lock_three | hi_byte[5];
				next_st.security_lock_two     = st.security_lock_two | hi_byte[4];
				next_st.security_lock_one     = st.security_lock_one | hi_byte[3];
				next_st.quad_enable           = hi_byte[1];
				next_st.register_protect_high = hi_byte[0];
			end
			if (opcode == `FSR_OP_WRITE_STATUS2 && bit_cnt == `FSR_TWO_BYTES) begin
				next_cfg = fsr_config_s'(byte2 & `FSR_CONFIG_MASK);
			end
			next_st.write_busy = 1'b1;
			next_tw_cnt        = STATUS_WRITE_CYCLES;
		end else if (st.write_busy) begin
			next_tw_cnt = tw_cnt - 32'h1;
			if (tw_cnt <= 32'h1) begin
				next_st.write_busy         = 1'b0;
				next_st.write_enable_latch = 1'b0;
				next_tw_cnt                = 32'h0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st     <= `FSR_STATUS_RESET;
			cfg    <= `FSR_CONFIG_RESET;
			tw_cnt <= 32'h0;
		end else begin
			st     <= next_st;
			cfg    <= next_cfg;
			tw_cnt <= next_tw_cnt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	fsr_status_s next_status_word;
	logic [8:0]  next_buf_addr;

	// Registered views and configuration effects
	always_comb begin
		next_status_word            = st;
		next_status_word.write_busy = st.write_busy | array_busy;
		next_buf_addr               = buf_addr;
		if (buf_load) begin
			next_buf_addr = buf_start;
		end else if (buf_strobe) begin
			if (cfg.large_page_select) begin
				next_buf_addr = buf_addr + 9'h1;
			end else begin
				next_buf_addr = {buf_addr[8], buf_addr[7:0] + 8'h1};
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_word        <= `FSR_STATUS_RESET;
			config_byte        <= `FSR_CONFIG_RESET;
			buf_addr           <= 9'h0;
			erase_dual_page    <= 1'b0;
			pin_hold_enable    <= 1'b1;
			pin_reset_enable   <= 1'b0;
			use_block_locks    <= 1'b0;
			block_locks_preset <= 1'b1;
			dual_dummy         <= `FSR_DUAL_DUMMY_SHORT;
			quad_dummy         <= `FSR_QUAD_DUMMY_SHORT;
			learn_pattern      <= 8'h0;
		end else begin
			status_word        <= next_status_word;
			config_byte        <= cfg;
			buf_addr           <= next_buf_addr;
			erase_dual_page    <= cfg.large_page_select;
			pin_hold_enable    <= ~st.quad_enable & ~cfg.hold_reset_select;
			pin_reset_enable   <= ~st.quad_enable & cfg.hold_reset_select;
			use_block_locks    <= cfg.protect_scheme_select;
			block_locks_preset <= 1'b0;
			dual_dummy         <= cfg.dummy_count_select ? `FSR_DUAL_DUMMY_LONG : `FSR_DUAL_DUMMY_SHORT;
			quad_dummy         <= cfg.dummy_count_select ? `FSR_QUAD_DUMMY_LONG : `FSR_QUAD_DUMMY_SHORT;
			learn_pattern      <= cfg.learning_pattern_enable ? `FSR_LEARN_BYTE : 8'h0;
		end
	end
endmodule : fsr_regs
`default_nettype wire

// ===== fsr_regs_asserts.sv
// Purpose: Concurrent checks on the ports of the flash status/config block
// Assumes: One clock domain, nrst as the disable condition
// Notes:   Bound to fsr_regs below the module
`timescale 1ns/100ps
`default_nettype none
module fsr_regs_asserts #(
	parameter int unsigned STATUS_WRITE_CYCLES = 250000
) (
	// Clock and reset
	input wire logic                 sys_clk,
	input wire logic                 nrst,
	// Link and core side
	input wire fsr_pkg::fsr_pins_s   pins,
	input wire logic [3:0]           io_out,
	input wire logic [3:0]           io_oe,
	input wire logic                 qpi_mode,
	input wire logic                 array_busy,
	input wire logic                 erase_fail,
	input wire logic                 buf_load,
	input wire logic [8:0]           buf_start,
	input wire logic                 buf_strobe,
	input wire logic [8:0]           buf_addr,
	// Effects and views
	input wire logic                 erase_dual_page,
	input wire logic                 pin_hold_enable,
	input wire logic                 pin_reset_enable,
	input wire logic                 use_block_locks,
	input wire logic                 block_locks_preset,
	input wire logic [3:0]           dual_dummy,
	input wire logic [3:0]           quad_dummy,
	input wire logic [7:0]           learn_pattern,
	input wire fsr_pkg::fsr_status_s status_word,
	input wire fsr_pkg::fsr_config_s config_byte
);
	import fsr_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic [31:0] busy_len;
	logic [31:0] next_busy_len;
	// ****************************************
	// Helper count of a write-cycle busy stretch
	// ****************************************
	always_comb begin
		next_busy_len = (status_word.write_busy && !array_busy) ? busy_len + 32'h1 : 32'h0;
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) busy_len <= 32'h0;
		else busy_len <= next_busy_len;
	end
	// Settled configuration, so registered effects have caught up
	sequence cfg_quiet;
		($stable(config_byte) && $stable(status_word.quad_enable)) [*3];
	endsequence
	a_dummy_counts: assert property (cfg_quiet |-> dual_dummy == (config_byte.dummy_count_select ? 4'h8 : 4'h4)
		&& quad_dummy == (config_byte.dummy_count_select ? 4'ha : 4'h6)) else $error("dummy count mismatch");
	a_learn_pat: assert property (cfg_quiet |-> learn_pattern == (config_byte.learning_pattern_enable ? 8'h34 : 8'h00))
		else $error("learning pattern mismatch");
	a_page_scheme: assert property (cfg_quiet |-> erase_dual_page == config_byte.large_page_select
		&& use_block_locks == config_byte.protect_scheme_select) else $error("page or scheme effect mismatch");
	a_pin_mode: assert property (cfg_quiet |-> pin_hold_enable == (!status_word.quad_enable
		&& !config_byte.hold_reset_select) && pin_reset_enable == (!status_word.quad_enable
		&& config_byte.hold_reset_select)) else $error("hold or reset pin mode mismatch");
	a_cfg_reserved: assert property (config_byte.reserved == 3'h0) else $error("reserved config bits set");
	a_locks_sticky: assert property (1'b1 |=> (status_word[13:11] & $past(status_word[13:11]))
		== $past(status_word[13:11])) else $error("lock bit cleared");
	a_err_copy: assert property ($stable(erase_fail) [*6] |-> status_word.erase_fail == erase_fail)
		else $error("fail bit not copied");
	a_busy_array: assert property (array_busy [*6] |-> status_word.write_busy) else $error("busy bit low");
	a_busy_len: assert property (busy_len <= STATUS_WRITE_CYCLES + 32'd4) else $error("write cycle too long");
	a_oe_idle: assert property (pins.cs_n [*5] |-> io_oe == 4'h0) else $error("driving while deselected");
	a_buf_step: assert property (buf_strobe && !buf_load |=> buf_addr == ($past(config_byte.large_page_select)
		? $past(buf_addr) + 9'h001 : {$past(buf_addr[8]), $past(buf_addr[7:0]) + 8'h01}))
		else $error("page buffer address step wrong");
	c_write: cover property ($rose(status_word.write_busy));
	c_read: cover property (io_oe == 4'h2);
	c_pause: cover property ($rose(status_word.pause_flag));
	c_wrap: cover property (buf_strobe && buf_addr[7:0] == 8'hff);
endmodule : fsr_regs_asserts
bind fsr_regs fsr_regs_asserts #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_asserts (.sys_clk(sys_clk), .nrst(nrst),
	.pins(pins), .io_out(io_out), .io_oe(io_oe), .qpi_mode(qpi_mode), .array_busy(array_busy),
	.erase_fail(erase_fail), .buf_load(buf_load), .buf_start(buf_start), .buf_strobe(buf_strobe),
	.buf_addr(buf_addr), .erase_dual_page(erase_dual_page), .pin_hold_enable(pin_hold_enable),
	.pin_reset_enable(pin_reset_enable), .use_block_locks(use_block_locks),
	.block_locks_preset(block_locks_preset), .dual_dummy(dual_dummy), .quad_dummy(quad_dummy),
	.learn_pattern(learn_pattern), .status_word(status_word), .config_byte(config_byte));
`default_nettype wire

// ===== fsr_sync.sv
// Purpose: Two flip-flop synchroniser for a group of levels
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module fsr_sync #(
	parameter int                WIDTH = 1,
	parameter logic [WIDTH-1:0]  INIT  = '0
) (
	// Clock and reset
	input  wire  logic             clk,
	input  wire  logic             rst_n,
	// Levels
	input  wire  logic [WIDTH-1:0] d,
	output logic       [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// Two stages toward the local clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= INIT;
			q    <= INIT;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : fsr_sync
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench of the flash status/config block
// Assumes: Short write cycle, single-line link, quad instruction mode off
// Notes:   Random write data from an xorshift seeded with 30
`include "fsr_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
	import fsr_pkg::*;
	logic        sys_clk = 1'b0, nrst = 1'b0, wp_lvl = 1'b1, array_busy = 1'b0, erase_fail = 1'b0;
	logic        buf_load = 1'b0, buf_strobe = 1'b0;
	logic [8:0]  buf_start = 9'h000, buf_addr;
	logic [31:0] seed = 32'd30;
	logic [15:0] model = 16'h0000;
	logic [7:0]  cfg_exp = 8'h00, rd, learn_pattern;
	logic [3:0]  io_out, io_oe, dual_dummy, quad_dummy;
	logic        erase_dual_page, pin_hold_enable, pin_reset_enable, use_block_locks, block_locks_preset;
	logic [8:0]  corner [2] = '{9'h0ff, 9'h1ff};
	int          bad_count = 0, check_count = 0, cyc = 0;
	fsr_pins_s   pins;
	fsr_status_s status_word;
	fsr_config_s config_byte;
	fsr_host u_host (.pins(pins), .io_out(io_out), .wp_lvl(wp_lvl));
	fsr_regs #(.STATUS_WRITE_CYCLES(400)) DUT (.sys_clk(sys_clk), .nrst(nrst), .pins(pins), .io_out(io_out),
		.io_oe(io_oe), .qpi_mode(1'b0), .array_busy(array_busy), .erase_fail(erase_fail), .buf_load(buf_load),
		.buf_start(buf_start), .buf_strobe(buf_strobe), .buf_addr(buf_addr), .erase_dual_page(erase_dual_page),
		.pin_hold_enable(pin_hold_enable), .pin_reset_enable(pin_reset_enable), .use_block_locks(use_block_locks),
		.block_locks_preset(block_locks_preset), .dual_dummy(dual_dummy), .quad_dummy(quad_dummy),
		.learn_pattern(learn_pattern), .status_word(status_word), .config_byte(config_byte));
	always #10 sys_clk = ~sys_clk;
	// Cut a hang short
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			$display("ERROR %0t run too long", $time);
			wrap_up();
		end
	end
	// ****************************************
	// Checking tasks and expectation functions
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [15:0] exp_status(input logic [15:0] cur, input logic [7:0] op, input logic [15:0] d,
		input int nd);
		logic [15:0] n;
		logic [7:0]  hi;
		n = cur;
		hi = (op == `FSR_OP_WRITE_STATUS) ? d[7:0] : d[15:8];
		if (op == `FSR_OP_WRITE_STATUS) n[7:2] = d[15:10];
		if (op == `FSR_OP_WRITE_STATUS && nd == 8) begin
			n[14] = 1'b0;
			n[9:8] = 2'b00;
		end else begin
			n[14] = hi[6];
			n[13:11] = cur[13:11] | hi[5:3];
			n[9:8] = hi[1:0];
		end
		return n;
	endfunction : exp_status
	// Write enable, write status, then poll through the cycle
	task automatic wrs(input logic [7:0] op, input logic [15:0] d, input int nd, input bit write_enable_cmd, input bit ok);
		if (write_enable_cmd) u_host.frame(`FSR_OP_WRITE_ENABLE, 16'h0000, 0, 0, rd);
		u_host.frame(op, d, nd, 0, rd);
		if (ok) model = exp_status(model, op, d, nd);
		if (ok && op == `FSR_OP_WRITE_STATUS2 && nd == 16) cfg_exp = d[7:0] & `FSR_CONFIG_MASK;
		chk(status_word[15:2], model[15:2], "status bits");
		chk(status_word.write_busy, ok, "busy");
		if (ok) begin
			u_host.frame(`FSR_OP_READ_STATUS_LO, 16'h0000, 0, 8, rd);
			chk(rd, {model[7:2], 2'b11}, "status read in cycle");
			u_host.frame(`FSR_OP_READ_CONFIG, 16'h0000, 0, 8, rd);
			chk(rd, cfg_exp, "config read in cycle");
			for (int i = 0; i < 1000 && status_word.write_busy !== 1'b0; i++) @(negedge sys_clk);
			chk(status_word[1:0], 2'b00, "cycle end");
		end
		chk(config_byte, cfg_exp, "config");
	endtask : wrs
	task automatic buf_chk(input logic [8:0] a);
		buf_start = a;
		buf_load = 1'b1;
		@(negedge sys_clk) buf_load = 1'b0;
		buf_strobe = 1'b1;
		@(negedge sys_clk) buf_strobe = 1'b0;
		chk(buf_addr, cfg_exp[3] ? 9'(a + 9'h001) : {a[8], a[7:0] + 8'h01}, "buffer wrap");
		chk(erase_dual_page, cfg_exp[3], "dual page");
	endtask : buf_chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	// Main sequence
	initial begin
		repeat (6) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (6) @(negedge sys_clk);
		chk(status_word, 16'h0000, "status reset");
		chk({dual_dummy, quad_dummy}, 8'h46, "dummy reset");
		chk({pin_hold_enable, block_locks_preset, learn_pattern}, 10'h200, "pin reset");
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			wrs(i[0] ? `FSR_OP_WRITE_STATUS2 : `FSR_OP_WRITE_STATUS, seed[15:0] & (i[0] ? 16'hfeff : 16'hfffe), 16, 1, 1);
		end
		wrs(`FSR_OP_WRITE_STATUS, 16'h1234, 16, 0, 0);
		wrs(`FSR_OP_WRITE_STATUS, 16'h1234, 4, 1, 0);
		wrs(`FSR_OP_WRITE_STATUS, 16'h1234, 12, 1, 0);
		$display("test random writes done");
		wrs(`FSR_OP_WRITE_STATUS2, 16'h00ff, 16, 1, 1);
		chk({dual_dummy, quad_dummy, learn_pattern}, 16'h8a34, "config effects");
		chk({use_block_locks, pin_reset_enable, pin_hold_enable}, 3'b110, "scheme and pin");
		foreach (corner[j]) buf_chk(corner[j]);
		wrs(`FSR_OP_WRITE_STATUS2, 16'h4200, 16, 1, 1);
		foreach (corner[j]) buf_chk(corner[j]);
		wrs(`FSR_OP_WRITE_STATUS2, 16'h4000, 8, 1, 1);
		wrs(`FSR_OP_WRITE_STATUS, 16'hfc00, 8, 1, 1);
		wp_lvl = 1'b0;
		wrs(`FSR_OP_WRITE_STATUS, 16'h0000, 16, 1, 0);
		wp_lvl = 1'b1;
		wrs(`FSR_OP_WRITE_STATUS, 16'h0000, 16, 1, 1);
		$display("test config and protect done");
		erase_fail = 1'b1;
		model[10] = 1'b1;
		u_host.frame(`FSR_OP_SUSPEND, 16'h0000, 0, 0, rd);
		model[15] = 1'b1;
		chk(status_word.pause_flag, 1'b1, "pause set");
		wrs(`FSR_OP_WRITE_STATUS, 16'h007e, 16, 1, 1);
		u_host.frame(`FSR_OP_RESUME, 16'h0000, 0, 0, rd);
		chk(status_word.pause_flag, 1'b0, "pause cleared");
		array_busy = 1'b1;
		repeat (8) @(negedge sys_clk);
		chk(status_word.write_busy, 1'b1, "array busy");
		array_busy = 1'b0;
		chk(io_oe, 4'h0, "drive idle");
		$display("test suspend and busy done");
		wrap_up();
	end
endmodule : tb
`default_nettype wire
